// ==== cache_bus_pkg.sv ====
// Purpose: shared constants, types and helpers for the cache-side bus master
// Assumes: 32-bit multiplexed address/data bus, byte parity, active-low reply lines
// Notes:   the widths, lags, beat limits and reset values used by the design files are named here once
package cache_bus_pkg;

  // ---------------------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LANES      = 4;
  localparam int unsigned LINE_WORDS = 4;
  localparam int unsigned REPLY_W    = 4;
  localparam int unsigned SYNC_W     = 1 + REPLY_W + DATA_W + LANES;

  // ---------------------------------------------------------------------------
  // timing: the input synchroniser delays every sampled pin by two clocks
  // ---------------------------------------------------------------------------
  localparam logic [1:0] REPLY_LAG      = 2'h2;
  localparam logic [1:0] LAST_BEAT_LINE = 2'h3;
  localparam logic [1:0] LAST_BEAT_ONE  = 2'h0;

  // ---------------------------------------------------------------------------
  // reset values and the all-lanes read mask
  // ---------------------------------------------------------------------------
  localparam logic [REPLY_W-1:0] LOCAL_REPLY_IDLE = 4'hF;
  localparam logic [SYNC_W-1:0]  SYNC_RESET       = '0;
  localparam logic [LANES-1:0]   LANES_ALL        = 4'hF;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    R_ERROR,
    R_RETRY,
    R_WAIT,
    R_END,
    R_OK
  } reply_t;

  typedef enum logic [1:0] {
    RES_OK,
    RES_ERROR,
    RES_PARITY
  } result_t;

  typedef struct packed {
    logic [DATA_W-1:0]                 addr;
    logic                              is_read;
    logic                              burst;
    logic                              modify;
    logic                              lock;
    logic                              inhibit;
    logic                              global;
    logic [LINE_WORDS-1:0][LANES-1:0]  lanes;
    logic [LINE_WORDS-1:0][DATA_W-1:0] wdata;
  } cmd_t;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // priority decode of the active-low system reply lines
  function automatic reply_t decode_reply(input logic [REPLY_W-1:0] lines);
    reply_t r;
    if (!lines[3])
      r = R_ERROR;
    else if (!lines[2])
      r = R_RETRY;
    else if (!lines[1])
      r = R_WAIT;
    else if (!lines[0])
      r = R_END;
    else
      r = R_OK;
    return r;
  endfunction

  // even parity, one bit per byte lane, lane 3 is the top byte
  function automatic logic [LANES-1:0] byte_parity(input logic [DATA_W-1:0] d);
    logic [LANES-1:0] p;
    for (int i = 0; i < LANES; i++)
      p[i] = ^d[i*8 +: 8];
    return p;
  endfunction

endpackage

// ==== pin_sync.sv ====
// Purpose: two-flop synchroniser for pins sampled from outside the clock domain
// Assumes: each bit is treated on its own; wide groups are sampled as levels
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned        W         = 1,
  parameter logic [W-1:0]       RESET_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== cache_bus_master.sv ====
// Purpose: cache-unit side bus master that runs address and data phases toward
//          the memory controller on the multiplexed, arbitrated bus
// Assumes: pins toward the bus are sampled through two flip-flops
// Notes:   one command runs one tenure, or more after a retry; line fills are four beats
`timescale 1ns/100ps
`default_nettype none
module cache_bus_master (
  input  wire logic                           clk_i,
  input  wire logic                           reset_i,
  // user command side
  input  wire logic                           cmd_valid_i,
  input  wire cache_bus_pkg::cmd_t            cmd_i,
  output logic                                cmd_ready_o,
  output logic [cache_bus_pkg::DATA_W-1:0]    rdata_o,
  output logic                                rdata_valid_o,
  output logic                                done_o,
  output cache_bus_pkg::result_t              result_o,
  // bus side
  output logic                                bus_request_line_o,
  input  wire logic                           bus_grant_line_i,
  output logic                                bus_ack_line_o,
  input  wire logic [cache_bus_pkg::DATA_W-1:0] muxed_bus_lines_i,
  output logic [cache_bus_pkg::DATA_W-1:0]    muxed_bus_lines_o,
  output logic                                muxed_bus_lines_oe_o,
  input  wire logic [cache_bus_pkg::LANES-1:0] muxed_bus_parity_i,
  output logic [cache_bus_pkg::LANES-1:0]     muxed_bus_parity_o,
  output logic                                muxed_bus_parity_oe_o,
  input  wire logic [cache_bus_pkg::REPLY_W-1:0] system_reply_lines_i,
  output logic [cache_bus_pkg::REPLY_W-1:0]   cmmu_local_reply_o,
  output logic                                phase_select_o,
  output logic                                modify_intent_or_final_beat_o,
  output logic                                read_not_write_o,
  output logic                                lock_or_lane_top_o,
  output logic                                inhibit_or_lane_upper_o,
  output logic                                shared_or_lane_lower_o,
  output logic                                reserved_or_lane_bottom_o
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_REQUEST,
    S_ACK,
    S_ADDR,
    S_DATA,
    S_FINISH
  } state_t;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [cache_bus_pkg::SYNC_W-1:0]  sync_bits;
  logic                              grant_s;
  logic [cache_bus_pkg::REPLY_W-1:0] reply_s;
  logic [cache_bus_pkg::DATA_W-1:0]  data_s;
  logic [cache_bus_pkg::LANES-1:0]   parity_s;

  pin_sync #(
    .W         (cache_bus_pkg::SYNC_W),
    .RESET_VAL (cache_bus_pkg::SYNC_RESET)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   ({bus_grant_line_i, system_reply_lines_i, muxed_bus_lines_i,
               muxed_bus_parity_i}),
    .sync_o  (sync_bits)
  );

  assign {grant_s, reply_s, data_s, parity_s} = sync_bits;

  // ---------------------------------------------------------------------------
  // state, command and beat tracking
  // ---------------------------------------------------------------------------
  state_t               state;
  state_t               next_state;
  cache_bus_pkg::cmd_t  cmd;
  logic [1:0]           beat;
  logic [1:0]           next_beat;
  logic [1:0]           last_beat;
  logic [1:0]           hold;
  logic                 reply_ok;
  logic                 beat_done;
  logic                 phase_change;
  logic                 fail;
  cache_bus_pkg::reply_t code;

  assign code      = cache_bus_pkg::decode_reply(reply_s);
  assign reply_ok  = (hold == 2'h0);
  assign last_beat = cmd.burst ? cache_bus_pkg::LAST_BEAT_LINE
                               : cache_bus_pkg::LAST_BEAT_ONE;

  always_comb
  begin
    next_state = state;
    beat_done  = 1'b0;
    fail       = 1'b0;
    unique case (state)
      S_IDLE:
        if (cmd_valid_i && cmd_ready_o)
          next_state = S_REQUEST;
      S_REQUEST:
        if (grant_s)
          next_state = S_ACK;
      S_ACK:
        next_state = S_ADDR;
      S_ADDR:
        if (reply_ok)
        begin
          unique case (code)
            cache_bus_pkg::R_ERROR:
            begin
              fail       = 1'b1;
              next_state = S_FINISH;
            end
            cache_bus_pkg::R_RETRY: next_state = S_REQUEST;
            cache_bus_pkg::R_WAIT:  next_state = S_ADDR;
            cache_bus_pkg::R_END,
            cache_bus_pkg::R_OK:    next_state = S_DATA;
          endcase
        end
      S_DATA:
        if (reply_ok)
        begin
          unique case (code)
            cache_bus_pkg::R_ERROR:
            begin
              fail       = 1'b1;
              next_state = S_FINISH;
            end
            cache_bus_pkg::R_RETRY: next_state = S_REQUEST;
            cache_bus_pkg::R_WAIT:  next_state = S_DATA;
            cache_bus_pkg::R_END,
            cache_bus_pkg::R_OK:
            begin
              beat_done = 1'b1;
              if (beat == last_beat)
                next_state = S_FINISH;
            end
          endcase
        end
      S_FINISH:
        next_state = S_IDLE;
    endcase
  end

  // a retry restarts the whole tenure from the first word
  assign next_beat = (next_state != S_DATA) ? 2'h0
                   : (beat_done ? beat + 2'h1 : beat);
  assign phase_change = (next_state != state) || beat_done;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      beat <= 2'h0;
    else
      beat <= next_beat;
  end

  // the reply of an earlier phase still sits in the synchroniser; ignore it
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      hold <= cache_bus_pkg::REPLY_LAG;
    else if (phase_change)
      hold <= cache_bus_pkg::REPLY_LAG;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cmd <= '0;
    else if (state == S_IDLE && cmd_valid_i && cmd_ready_o)
      cmd <= cmd_i;
  end

  // ---------------------------------------------------------------------------
  // user side results
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_ready_o   <= 1'b1;
      done_o        <= 1'b0;
      result_o      <= cache_bus_pkg::RES_OK;
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      cmd_ready_o   <= (next_state == S_IDLE);
      done_o        <= (next_state == S_FINISH);
      rdata_valid_o <= beat_done && cmd.is_read;
      if (beat_done && cmd.is_read)
        rdata_o <= data_s;
      if (state == S_REQUEST && next_state == S_ACK)
        result_o <= cache_bus_pkg::RES_OK;
      else if (fail)
        result_o <= cache_bus_pkg::RES_ERROR;
      else if (beat_done && cmd.is_read &&
               cache_bus_pkg::byte_parity(data_s) != parity_s &&
               result_o == cache_bus_pkg::RES_OK)
        result_o <= cache_bus_pkg::RES_PARITY;
    end
  end

  // ---------------------------------------------------------------------------
  // bus pins, registered from the next state
  // ---------------------------------------------------------------------------
  logic in_addr;
  logic in_data;
  logic write_beat;

  assign in_addr    = (next_state == S_ADDR);
  assign in_data    = (next_state == S_DATA);
  assign write_beat = in_data && !cmd.is_read;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bus_request_line_o <= 1'b0;
      bus_ack_line_o     <= 1'b0;
      cmmu_local_reply_o <= cache_bus_pkg::LOCAL_REPLY_IDLE;
    end
    else
    begin
      bus_request_line_o <= (next_state == S_REQUEST) || (next_state == S_ACK) ||
                            in_addr || in_data;
      bus_ack_line_o     <= (next_state == S_ACK) || in_addr || in_data;
      cmmu_local_reply_o <= cache_bus_pkg::LOCAL_REPLY_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      muxed_bus_lines_o     <= '0;
      muxed_bus_lines_oe_o  <= 1'b0;
      muxed_bus_parity_o    <= '0;
      muxed_bus_parity_oe_o <= 1'b0;
    end
    else
    begin
      muxed_bus_lines_oe_o  <= in_addr || write_beat;
      muxed_bus_parity_oe_o <= in_addr || write_beat;
      if (in_addr)
      begin
        muxed_bus_lines_o  <= cmd.addr;
        muxed_bus_parity_o <= cache_bus_pkg::byte_parity(cmd.addr);
      end
      else
      begin
        muxed_bus_lines_o  <= cmd.wdata[next_beat];
        muxed_bus_parity_o <= cache_bus_pkg::byte_parity(cmd.wdata[next_beat]);
      end
    end
  end

  logic [cache_bus_pkg::LANES-1:0] lanes;
  assign lanes = cmd.is_read ? cache_bus_pkg::LANES_ALL : cmd.lanes[next_beat];

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_select_o                <= 1'b0;
      modify_intent_or_final_beat_o <= 1'b0;
      read_not_write_o              <= 1'b0;
      lock_or_lane_top_o            <= 1'b0;
      inhibit_or_lane_upper_o       <= 1'b0;
      shared_or_lane_lower_o        <= 1'b0;
      reserved_or_lane_bottom_o     <= 1'b0;
    end
    else
    begin
      phase_select_o   <= in_addr;
      read_not_write_o <= (in_addr || in_data) && cmd.is_read;
      if (in_addr)
      begin
        modify_intent_or_final_beat_o <= cmd.modify || !cmd.is_read;
        lock_or_lane_top_o            <= cmd.lock;
        inhibit_or_lane_upper_o       <= cmd.inhibit;
        shared_or_lane_lower_o        <= cmd.global;
        reserved_or_lane_bottom_o     <= 1'b0;
      end
      else if (in_data)
      begin
        modify_intent_or_final_beat_o <= (next_beat == last_beat);
        lock_or_lane_top_o            <= lanes[3];
        inhibit_or_lane_upper_o       <= lanes[2];
        shared_or_lane_lower_o        <= lanes[1];
        reserved_or_lane_bottom_o     <= lanes[0];
      end
      else
      begin
        modify_intent_or_final_beat_o <= 1'b0;
        lock_or_lane_top_o            <= 1'b0;
        inhibit_or_lane_upper_o       <= 1'b0;
        shared_or_lane_lower_o        <= 1'b0;
        reserved_or_lane_bottom_o     <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence addr_phase_s;
    phase_select_o && bus_ack_line_o;
  endsequence

  sequence data_phase_s;
    !phase_select_o && bus_ack_line_o && (state == S_DATA);
  endsequence

  phase_owned_a: assert property (phase_select_o |-> bus_ack_line_o)
    else $error("address phase driven without bus ownership");
  ack_after_grant_a: assert property ($rose(bus_ack_line_o) |-> $past(grant_s))
    else $error("acknowledge raised without a sampled grant");
  ack_before_addr_a: assert property ($rose(phase_select_o) |-> $past(bus_ack_line_o))
    else $error("address phase started before acknowledge");
  reserved_zero_a: assert property (addr_phase_s |-> !reserved_or_lane_bottom_o)
    else $error("reserved control line driven in address phase");
  write_modify_a: assert property (addr_phase_s and !read_not_write_o
                                   |-> modify_intent_or_final_beat_o)
    else $error("write address phase without modify intent");
  addr_to_data_a: assert property (addr_phase_s ##1 (!phase_select_o && bus_ack_line_o)
                                   |-> data_phase_s)
    else $error("phase select dropped outside a data phase");
  rw_held_a: assert property (data_phase_s |-> read_not_write_o == cmd.is_read)
    else $error("read/write line wrong in data phase");
  write_drive_a: assert property (data_phase_s and muxed_bus_lines_oe_o
                                  |-> !read_not_write_o)
    else $error("bus lines driven in a read data phase");
  final_beat_a: assert property ((state == S_DATA) && beat == last_beat
                                 |-> modify_intent_or_final_beat_o)
    else $error("last data phase without final-beat line");
  retry_release_a: assert property ((state == S_ADDR) && reply_ok &&
                                    code == cache_bus_pkg::R_RETRY
                                    |=> !bus_ack_line_o ##1 bus_request_line_o)
    else $error("retry reply did not release the bus");
  error_done_a: assert property (((state == S_ADDR) || (state == S_DATA)) && reply_ok &&
                                 code == cache_bus_pkg::R_ERROR
                                 |=> done_o && result_o == cache_bus_pkg::RES_ERROR)
    else $error("error reply did not end the transfer");

endmodule
`default_nettype wire

// ==== mem_model.sv ====
// Purpose: behavioural memory controller on the far side of the bus master
// Assumes: 16-word array; replies are one-cycle OK, error or retry pulses between waits
// Notes:   mode_i 1 answers error, 2 retries once; extra_i slows every beat
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [3:0]  extra_i,
  input  wire logic [31:0] bad_i,
  input  wire logic        req_i,
  input  wire logic        ack_i,
  input  wire logic        phase_i,
  input  wire logic [5:0]  ctl_i,
  input  wire logic        oe_i,
  input  wire logic [31:0] md_i,
  input  wire logic [3:0]  mp_i,
  output logic             grant_o,
  output logic [3:0]       reply_o,
  output logic [31:0]      bus_o,
  output logic [3:0]       bpar_o,
  output logic [31:0]      addr_o,
  output logic [5:0]       ctl_o,
  output logic             perr_o,
  output logic [31:0]      fail_o
);
  logic [31:0] mem [16];
  logic [3:0]  par [16];
  logic [1:0]  st;
  logic [3:0]  cnt;
  logic [1:0]  beat;
  logic        retried;
  logic        ok;
  logic [3:0]  idx;
  logic [3:0]  gap;
  logic [31:0] wword;

  function automatic logic [3:0] pg(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 32'h0;
      par[i] = 4'h0;
    end
  end

  assign idx = addr_o[5:2] + {2'h0, beat};
  assign gap = (st == 2'h1 ? 4'h2 : beat != 2'h0 ? 4'h3 : ctl_o[4] ? 4'h4 : 4'h5) + extra_i;
  assign ok = (st == 2'h1 || (st == 2'h2 && !phase_i)) && cnt == gap;
  // a released bus shows the inverse word, never a stale copy
  assign bus_o = oe_i ? md_i : st == 2'h2 && ctl_o[4] ? mem[idx] : ~mem[idx];
  assign bpar_o = oe_i ? mp_i : par[idx] ^ {3'h0, {addr_o[31:6], idx, 2'h0} == bad_i};

  always_comb
    for (int i = 0; i < 4; i++)
      wword[i*8 +: 8] = ctl_i[i] ? md_i[i*8 +: 8] : mem[idx][i*8 +: 8];

  always_comb
  begin
    // answer wait for the whole tenure: the master reads replies two flops late, so an
    // idle all-high seen just after its address phase opens would pass for ok
    reply_o = ack_i ? 4'hD : 4'hF;
    if (ok)
      reply_o = st == 2'h2 || mode_i == 2'h0 ? 4'hF : mode_i == 2'h1 ? 4'h7 : retried ? 4'hF : 4'hB;
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st <= 2'h0;
      beat <= 2'h0;
      retried <= 1'b0;
      perr_o <= 1'b0;
      grant_o <= 1'b0;
    end
    else
    begin
      grant_o <= req_i;
      cnt <= st == 2'h0 || (st == 2'h2 && phase_i) || ok ? 4'h0 : cnt + 4'h1;
      if (st == 2'h0 && ack_i && phase_i)
      begin
        st <= 2'h1;
        addr_o <= md_i;
        ctl_o <= ctl_i;
      end
      if (ok && st == 2'h1)
        st <= reply_o == 4'hF ? 2'h2 : 2'h3;
      if (ok && reply_o == 4'hB)
        retried <= 1'b1;
      if (ok && st == 2'h2)
      begin
        beat <= beat + 2'h1;
        if (!ctl_o[4])
        begin
          mem[idx] <= wword;
          par[idx] <= pg(wword);
        end
        if (ctl_o[4] && bpar_o != pg(bus_o) && !perr_o)
        begin
          perr_o <= 1'b1;
          fail_o <= {addr_o[31:6], idx, 2'h0};
        end
        if (ctl_i[5])
        begin
          st <= 2'h0;
          beat <= 2'h0;
          retried <= 1'b0;
        end
      end
      if (!ack_i && st != 2'h0)
        st <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== test_cache_bus_master.sv ====
// Purpose: self-checking bench for the cache-side bus master
// Assumes: memory model on the far side, its replies wired with the local ones
// Notes:   t_reset checks idle outputs; each other scenario task drives commands and judges what comes back
`timescale 1ns/100ps
`default_nettype none
module test_cache_bus_master;
  logic                        clk_i = 1'b0;
  logic                        reset_i = 1'b1;
  logic                        valid = 1'b0;
  cache_bus_pkg::cmd_t         cmd = '0;
  logic [1:0]                  mode = 2'h0;
  logic [3:0]                  extra = 4'h0;
  logic [31:0]                 bad = 32'hFFFFFFFF;
  wire logic                   ready, rv, done, req, grant, ack, oe, poe, phase, perr;
  wire logic [31:0]            rdata, md, bus, addr, fail;
  wire logic [3:0]             mp, bpar, loc, rep;
  wire logic [5:0]             ctl, cap;
  wire cache_bus_pkg::result_t res;
  logic [31:0]                 rq [$];
  int                          mismatches = 0;
  int                          compares = 0;

  always #2 clk_i = ~clk_i;

  cache_bus_master u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(valid), .cmd_i(cmd),
    .cmd_ready_o(ready), .rdata_o(rdata), .rdata_valid_o(rv), .done_o(done),
    .result_o(res), .bus_request_line_o(req), .bus_grant_line_i(grant),
    .bus_ack_line_o(ack), .muxed_bus_lines_i(bus), .muxed_bus_lines_o(md),
    .muxed_bus_lines_oe_o(oe), .muxed_bus_parity_i(bpar), .muxed_bus_parity_o(mp),
    .muxed_bus_parity_oe_o(poe), .system_reply_lines_i(rep & loc),
    .cmmu_local_reply_o(loc), .phase_select_o(phase),
    .modify_intent_or_final_beat_o(ctl[5]), .read_not_write_o(ctl[4]),
    .lock_or_lane_top_o(ctl[3]), .inhibit_or_lane_upper_o(ctl[2]),
    .shared_or_lane_lower_o(ctl[1]), .reserved_or_lane_bottom_o(ctl[0])
  );

  mem_model u_mem (
    .clk_i(clk_i), .reset_i(reset_i), .mode_i(mode), .extra_i(extra), .bad_i(bad),
    .req_i(req), .ack_i(ack), .phase_i(phase), .ctl_i(ctl), .oe_i(oe), .md_i(md),
    .mp_i(mp), .grant_o(grant), .reply_o(rep), .bus_o(bus), .bpar_o(bpar),
    .addr_o(addr), .ctl_o(cap), .perr_o(perr), .fail_o(fail)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic run(input logic [31:0] a, input logic rd, input logic bst,
                     input logic [3:0] ln, input logic [31:0] d);
    int i;
    logic [3:0] ep;
    cmd.addr = a;
    cmd.is_read = rd;
    cmd.burst = bst;
    cmd.modify = a[4];
    cmd.lock = a[2];
    cmd.inhibit = a[3];
    cmd.global = rd;
    for (i = 0; i < 4; i++)
    begin
      cmd.lanes[i] = ln;
      cmd.wdata[i] = d + i;
    end
    valid = 1'b1;
    @(negedge clk_i);
    valid = 1'b0;
    rq.delete();
    for (i = 0; i < 500 && done !== 1'b1; i++)
    begin
      @(negedge clk_i);
      if (rv === 1'b1)
        rq.push_back(rdata);
      ep = {^md[31:24], ^md[23:16], ^md[15:8], ^md[7:0]};
      if (oe === 1'b1)
        check({27'h0, poe, mp}, {28'h1, ep}, "bus parity");
    end
    // a hung command counts once and leaves the verdict to the end of the run
    if (i == 500)
    begin
      check(32'h0, 32'h1, "no completion");
      return;
    end
    check({30'h0, cap[5:4]}, {30'h0, a[4] | ~rd, rd}, "modify, read");
    check({30'h0, cap[3:2]}, {30'h0, a[2], a[3]}, "lock, inhibit");
    check({30'h0, cap[1:0]}, {30'h0, rd, 1'b0}, "global, reserved");
    check(addr, a, "address");
    @(negedge clk_i);
  endtask

  task automatic t_reset();
    check({27'h0, ready, req, oe, phase, ack}, 32'h10, "idle outputs");
    check({28'h0, rep & loc}, 32'hF, "idle reply");
  endtask

  task automatic t_lanes();
    run(32'h0, 1'b0, 1'b0, 4'hF, 32'h11223344);
    run(32'h0, 1'b0, 1'b0, 4'h5, 32'hAABBCCDD);
    run(32'h0, 1'b1, 1'b0, 4'hF, 32'h0);
    check(32'(rq.size()), 32'h1, "single beats");
    check(rq[0], 32'h11BB33DD, "lane merge");
  endtask

  task automatic t_burst(input logic [3:0] x);
    extra = x;
    run(32'h1C, 1'b0, 1'b1, 4'hF, 32'hC0DE0000 + x);
    run(32'h1C, 1'b1, 1'b1, 4'hF, 32'h0);
    check(32'(rq.size()), 32'h4, "line beats");
    for (int i = 0; i < 4; i++)
      check(rq[i], 32'hC0DE0000 + x + i, "line word");
    check(32'(res), 32'(cache_bus_pkg::RES_OK), "line result");
    extra = 4'h0;
  endtask

  task automatic t_parity();
    bad = 32'h24;
    run(32'h1C, 1'b1, 1'b1, 4'hF, 32'h0);
    bad = 32'hFFFFFFFF;
    check(32'(res), 32'(cache_bus_pkg::RES_PARITY), "parity result");
    check(rq[2], 32'hC0DE0005, "word still returned");
    check({31'h0, perr}, 32'h1, "parity flag");
    check(fail, 32'h24, "failing address");
  endtask

  task automatic t_reply();
    for (int m = 1; m < 3; m++)
    begin
      mode = m[1:0];
      run(32'h0, 1'b1, 1'b0, 4'hF, 32'h0);
      check(32'(res), m == 1 ? 32'(cache_bus_pkg::RES_ERROR) : 32'h0, "reply result");
      check(32'(rq.size()), 32'(m - 1), "reply beats");
    end
    check(rq[0], 32'h11BB33DD, "retried read");
    mode = 2'h0;
  endtask

  initial
  begin
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    t_reset();
    t_lanes();
    t_burst(4'h0);
    t_burst(4'h3);
    t_parity();
    t_reply();
    results();
  end
endmodule
`default_nettype wire
